// file: asq_consts.svh
// Register map, field positions, reset values and timing constants of the light measurement sequencer
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASQ_ADDR_CTRL 8'h80
`define ASQ_ADDR_INTEG 8'h81
`define ASQ_ADDR_WAIT 8'h83
`define ASQ_ADDR_THR_LO 8'h84
`define ASQ_ADDR_THR_HI 8'h85
`define ASQ_ADDR_CFG0 8'h8D

// ----------------------------------------
// Reset values and read filler
// ----------------------------------------
`define ASQ_CTRL_RESET 8'h00
`define ASQ_INTEG_RESET 8'h00
`define ASQ_WAIT_RESET 8'h00
`define ASQ_THR_LO_RESET 8'h00
`define ASQ_THR_RESET 16'h0000
`define ASQ_CFG0_RESET 8'h80
`define ASQ_RD_UNMAPPED 8'h00
`define ASQ_CTRL_RSVD_MASK 8'h0B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASQ_BIT_OSC_POWER 0
`define ASQ_BIT_LIGHT_ON 1
`define ASQ_BIT_WEN 3
`define ASQ_BIT_WLONG 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASQ_CLK_PERIOD_NS 20
`define ASQ_STEP_TIME_NS 2780000
`define ASQ_STEP_CYCLES (`ASQ_STEP_TIME_NS / `ASQ_CLK_PERIOD_NS)
`define ASQ_STEP_CNT_W 18
`define ASQ_STEP_ZERO 18'h00000
`define ASQ_LONG_LAST 4'hB
`define ASQ_LONG_ZERO 4'h0
`define ASQ_LONG_ONE 4'h1
`define ASQ_CNT_ZERO 8'h00
`define ASQ_CNT_ONE 8'h01

// ----------------------------------------
// Result ceiling
// ----------------------------------------
`define ASQ_SAT_FIELD 2'h0
`define ASQ_SAT_MSB 7
`define ASQ_SAT_LSB 6
`define ASQ_STEPS_MSB 5
`define ASQ_MAX_COUNT 16'hFFFF
`define ASQ_STEP_LSBS 10'h3FF
`define ASQ_MAX_RESET 16'h03FF

`endif

// file: asq_host_model.sv
// Host model driving the register port of the light measurement sequencer
`timescale 1ns/1ps
module asq_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output asq_pkg::asq_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_req = '0;
	end
	// One-cycle request; strobes then drop to zero, released address and data lines show inverted values
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		reg_req <= {w, ~w, a, d};
		@(posedge clk);
		reg_req <= {2'b00, ~a, ~d};
		@(negedge clk);
		q = reg_rdata;
	endtask
	// Settings first, then power and enable in one write
	task automatic start(input logic [7:0] integ, input logic [7:0] wt, input logic [7:0] ctrl);
		logic [7:0] q;
		xfer(1'b1, 8'h81, integ, q);
		xfer(1'b1, 8'h83, wt, q);
		xfer(1'b1, 8'h80, ctrl | 8'h03, q);
	endtask
endmodule

// file: asq_pkg.sv
// Types shared by the light measurement sequencer
package asq_pkg;

	// ----------------------------------------
	// Register port request
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} asq_reg_req_t;

	// ----------------------------------------
	// Sequencer status
	// ----------------------------------------
	typedef struct packed {
		logic osc_on;
		logic az_active;
		logic integrating;
		logic waiting;
	} asq_status_t;

	typedef enum logic [3:0] {
		ASQ_IDLE = 4'h1,
		ASQ_AZ = 4'h2,
		ASQ_INTEG = 4'h4,
		ASQ_WAIT = 4'h8
	} asq_state_t;

endpackage

// file: asq_sequencer.sv
// Light measurement sequencer: control registers, step timebase, integration and wait timers
`timescale 1ns/1ps
`include "asq_consts.svh"

// Function
// - Power bit starts and stops step oscillator
// - Wait enable bit inserts wait phase
// - Measurement cycles run only while enabled
// - Both bits in one write: auto-zero first
// - Integration down counter, setting N: N+1 steps
// - Max count 1024 per step minus one, saturating
// - Wait down counter, setting N: N+1 steps
// - Long-wait bit stretches each wait step twelvefold
// - Holds low threshold low byte register
// - Low byte applied only with high byte
module asq_sequencer #(
	parameter int STEP_CYCLES = `ASQ_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input asq_pkg::asq_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Sequencer outputs
	output asq_pkg::asq_status_t status,
	output logic step_tick,
	output logic integ_done,
	output logic [15:0] max_count,
	output logic [15:0] low_threshold
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] integ_q;
	logic [7:0] wait_q;
	logic [7:0] thr_lo_q;
	logic [7:0] cfg0_q;
	logic [15:0] thr_q;
	logic [7:0] rdata_q;
	logic [15:0] max_q;
	logic az_pend_q;
	logic done_q;
	logic [`ASQ_STEP_CNT_W-1:0] div_q;
	logic [3:0] lw_q;
	logic [7:0] cnt_q;
	asq_pkg::asq_state_t state_q;
	asq_pkg::asq_state_t state_d;
	logic [7:0] cnt_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire wr_ctrl = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_CTRL);
	wire wr_integ = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_INTEG);
	wire wr_wait = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_WAIT);
	wire wr_thr_lo = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_THR_LO);
	wire wr_thr_hi = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_THR_HI);
	wire wr_cfg0 = reg_req.wr && hit(reg_req.addr, `ASQ_ADDR_CFG0);
	wire oscillator_power_bit = ctrl_q[`ASQ_BIT_OSC_POWER];
	wire light_measure_on = ctrl_q[`ASQ_BIT_LIGHT_ON];
	wire wen = ctrl_q[`ASQ_BIT_WEN];
	wire wlong = cfg0_q[`ASQ_BIT_WLONG];
	wire run = oscillator_power_bit && light_measure_on;
	wire both_set = reg_req.wdata[`ASQ_BIT_OSC_POWER] && reg_req.wdata[`ASQ_BIT_LIGHT_ON];
	wire az_set = wr_ctrl && both_set && !run;
	wire [7:0] rd_mux =
		hit(reg_req.addr, `ASQ_ADDR_CTRL) ? ctrl_q :
		hit(reg_req.addr, `ASQ_ADDR_INTEG) ? integ_q :
		hit(reg_req.addr, `ASQ_ADDR_WAIT) ? wait_q :
		hit(reg_req.addr, `ASQ_ADDR_THR_LO) ? thr_lo_q :
		hit(reg_req.addr, `ASQ_ADDR_CFG0) ? cfg0_q : `ASQ_RD_UNMAPPED;

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	wire tick = oscillator_power_bit && (div_q == (`ASQ_STEP_CNT_W)'(STEP_CYCLES - 1));
	wire wait_tick = tick && (!wlong || lw_q == `ASQ_LONG_LAST);
	wire cnt_zero = (cnt_q == `ASQ_CNT_ZERO);
	wire integ_fin = (state_q == asq_pkg::ASQ_INTEG) && tick && cnt_zero;
	wire wait_fin = (state_q == asq_pkg::ASQ_WAIT) && wait_tick && cnt_zero;
	wire sat_field_clear = (integ_q[`ASQ_SAT_MSB:`ASQ_SAT_LSB] == `ASQ_SAT_FIELD);
	wire [15:0] max_d = sat_field_clear ? {integ_q[`ASQ_STEPS_MSB:0], `ASQ_STEP_LSBS} : `ASQ_MAX_COUNT;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `ASQ_CTRL_RESET;
			integ_q <= `ASQ_INTEG_RESET;
			wait_q <= `ASQ_WAIT_RESET;
			cfg0_q <= `ASQ_CFG0_RESET;
		end else begin
			if (wr_ctrl) ctrl_q <= reg_req.wdata & `ASQ_CTRL_RSVD_MASK;
			if (wr_integ) integ_q <= reg_req.wdata;
			if (wr_wait) wait_q <= reg_req.wdata;
			if (wr_cfg0) cfg0_q <= reg_req.wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			thr_lo_q <= `ASQ_THR_LO_RESET;
			thr_q <= `ASQ_THR_RESET;
		end else begin
			if (wr_thr_lo) thr_lo_q <= reg_req.wdata;
			if (wr_thr_hi) thr_q <= {reg_req.wdata, thr_lo_q};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= `ASQ_RD_UNMAPPED;
			max_q <= `ASQ_MAX_RESET;
		end else begin
			if (reg_req.rd) rdata_q <= rd_mux;
			max_q <= max_d;
		end
	end

	// ----------------------------------------
	// Step divider, gated by power bit
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= `ASQ_STEP_ZERO;
		end else if (!oscillator_power_bit || tick) begin
			div_q <= `ASQ_STEP_ZERO;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// Twelve-tick prescaler for long wait steps
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lw_q <= `ASQ_LONG_ZERO;
		end else if (state_q != asq_pkg::ASQ_WAIT || wait_tick) begin
			lw_q <= `ASQ_LONG_ZERO;
		end else if (tick) begin
			lw_q <= lw_q + 1'b1;
		end
	end

	// Auto-zero request: a new request wins over the consuming clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			az_pend_q <= 1'b0;
		end else if (az_set) begin
			az_pend_q <= 1'b1;
		end else if (state_q == asq_pkg::ASQ_AZ || !run) begin
			az_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			asq_pkg::ASQ_IDLE: begin
				if (run && az_pend_q) begin
					state_d = asq_pkg::ASQ_AZ;
				end else if (run) begin
					state_d = asq_pkg::ASQ_INTEG;
					cnt_d = integ_q;
				end
			end
			asq_pkg::ASQ_AZ: begin
				if (tick) begin
					state_d = asq_pkg::ASQ_INTEG;
					cnt_d = integ_q;
				end
			end
			asq_pkg::ASQ_INTEG: begin
				if (integ_fin && wen) begin
					state_d = asq_pkg::ASQ_WAIT;
					cnt_d = wait_q;
				end else if (integ_fin) begin
					cnt_d = integ_q;
				end else if (tick) begin
					cnt_d = cnt_q - `ASQ_CNT_ONE;
				end
			end
			asq_pkg::ASQ_WAIT: begin
				if (wait_fin) begin
					state_d = asq_pkg::ASQ_INTEG;
					cnt_d = integ_q;
				end else if (wait_tick) begin
					cnt_d = cnt_q - `ASQ_CNT_ONE;
				end
			end
			default: begin
				state_d = asq_pkg::ASQ_IDLE;
			end
		endcase
		if (!run) begin
			state_d = asq_pkg::ASQ_IDLE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= asq_pkg::ASQ_IDLE;
			cnt_q <= `ASQ_CNT_ZERO;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			done_q <= integ_fin && run;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = rdata_q;
	assign status.osc_on = oscillator_power_bit;
	assign status.az_active = (state_q == asq_pkg::ASQ_AZ);
	assign status.integrating = (state_q == asq_pkg::ASQ_INTEG);
	assign status.waiting = (state_q == asq_pkg::ASQ_WAIT);
	assign step_tick = tick;
	assign integ_done = done_q;
	assign max_count = max_q;
	assign low_threshold = thr_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	tick_needs_power_a: assert property (step_tick |-> status.osc_on)
		else $error("step tick while oscillator off");

	power_off_idle_a: assert property (!run |=> state_q == asq_pkg::ASQ_IDLE && !integ_done)
		else $error("sequencer active without power and enable");

	wait_inserted_a: assert property (integ_fin && run && wen |=> integ_done
		&& state_q == asq_pkg::ASQ_WAIT && cnt_q == $past(wait_q))
		else $error("wait phase not entered with loaded count");

	wait_skipped_a: assert property (integ_fin && run && !wen |=> integ_done
		&& state_q == asq_pkg::ASQ_INTEG && cnt_q == $past(integ_q))
		else $error("integration not restarted without wait");

	integ_countdown_a: assert property (state_q == asq_pkg::ASQ_INTEG && tick && !cnt_zero && run
		|=> cnt_q == $past(cnt_q) - `ASQ_CNT_ONE && state_q == asq_pkg::ASQ_INTEG)
		else $error("integration counter did not step down");

	wait_countdown_a: assert property (state_q == asq_pkg::ASQ_WAIT && wait_tick && !cnt_zero && run
		|=> cnt_q == $past(cnt_q) - `ASQ_CNT_ONE)
		else $error("wait counter did not step down");

	long_step_a: assert property (state_q == asq_pkg::ASQ_WAIT && wlong && tick
		&& lw_q != `ASQ_LONG_LAST && run |=> $stable(cnt_q) && lw_q == $past(lw_q) + `ASQ_LONG_ONE)
		else $error("long wait step ended early");

	autozero_first_a: assert property (state_q == asq_pkg::ASQ_IDLE && run && az_pend_q
		|=> state_q == asq_pkg::ASQ_AZ ##1 (!az_pend_q || $past(az_set)))
		else $error("auto-zero skipped before first integration");

	az_hold_a: assert property (state_q == asq_pkg::ASQ_AZ && !tick && run |=> state_q == asq_pkg::ASQ_AZ)
		else $error("auto-zero left before step tick");

	az_exit_a: assert property (state_q == asq_pkg::ASQ_AZ && tick && run
		|=> state_q == asq_pkg::ASQ_INTEG && cnt_q == $past(integ_q))
		else $error("integration not loaded after auto-zero");

	div_stopped_a: assert property (!oscillator_power_bit |=> div_q == `ASQ_STEP_ZERO)
		else $error("step divider running without power");

	max_sat_a: assert property (!sat_field_clear |=> max_count == `ASQ_MAX_COUNT)
		else $error("maximum count not saturated");

	max_scale_a: assert property (sat_field_clear
		|=> max_count == {$past(integ_q[`ASQ_STEPS_MSB:0]), `ASQ_STEP_LSBS})
		else $error("maximum count not 1024 per step minus one");

	thr_readback_a: assert property (reg_req.rd && hit(reg_req.addr, `ASQ_ADDR_THR_LO)
		|=> reg_rdata == $past(thr_lo_q))
		else $error("low threshold byte not read back");

	thr_hold_a: assert property (!wr_thr_hi |=> $stable(low_threshold))
		else $error("threshold changed without high byte write");

	thr_pair_a: assert property (wr_thr_hi |=> low_threshold == {$past(reg_req.wdata), $past(thr_lo_q)})
		else $error("threshold bytes not applied together");

	cover_autozero_c: cover property (state_q == asq_pkg::ASQ_AZ ##1 state_q == asq_pkg::ASQ_INTEG);
	cover_long_wait_c: cover property (state_q == asq_pkg::ASQ_WAIT && wlong && wait_fin);
	cover_repeat_c: cover property (integ_done ##[1:20] integ_done);
	cover_thr_c: cover property (wr_thr_lo ##1 wr_thr_hi);

endmodule

// file: asq_sequencer_tb.sv
// Self-checking testbench of the light measurement sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module asq_sequencer_tb;
	localparam int SC = 8;
	logic clk;
	logic arst_n;
	asq_pkg::asq_reg_req_t reg_req;
	asq_pkg::asq_status_t status;
	logic [7:0] reg_rdata;
	logic step_tick;
	logic integ_done;
	logic [15:0] max_count;
	logic [15:0] low_threshold;
	logic [5:0] obs;
	int error_cnt = 0;
	int cmp_count = 0;
	int n;
	assign obs = {integ_done, step_tick, status};
	asq_sequencer #(.STEP_CYCLES(SC)) u_dut (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.status(status), .step_tick(step_tick), .integ_done(integ_done), .max_count(max_count),
		.low_threshold(low_threshold));
	asq_host_model u_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_host.xfer(1'b0, a, 8'h00, q);
		`CHK("reg_rdata", e, q)
	endtask
	// Length of the next high phase of an observed signal
	task automatic phase_len(input int b, output int len);
		len = 0;
		for (int k = 0; k < 3000 && obs[b] === 1'b1; k++) @(negedge clk);
		for (int k = 0; k < 3000 && obs[b] !== 1'b1; k++) @(negedge clk);
		while (obs[b] === 1'b1 && len < 3000) begin
			@(negedge clk);
			len++;
		end
	endtask
	task automatic count_hi(input int b, input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(negedge clk);
			cnt += (obs[b] === 1'b1);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_chk(8'h80, 8'h00);
		rd_chk(8'h81, 8'h00);
		rd_chk(8'h83, 8'h00);
		rd_chk(8'h84, 8'h00);
		rd_chk(8'h8D, 8'h80);
		rd_chk(8'h82, 8'h00);
		`CHK("max_count", 16'h03FF, max_count)
		`CHK("low_threshold", 16'h0000, low_threshold)
		$display("t_reset done");
	endtask
	task automatic t_regs;
		wr(8'h80, 8'hF4);
		rd_chk(8'h80, 8'h00);
		wr(8'h80, 8'h08);
		rd_chk(8'h80, 8'h08);
		wr(8'h80, 8'h00);
		wr(8'h83, 8'h5A);
		rd_chk(8'h83, 8'h5A);
		wr(8'h8D, 8'h84);
		rd_chk(8'h8D, 8'h84);
		wr(8'h8D, 8'h80);
		wr(8'h84, 8'h3C);
		rd_chk(8'h84, 8'h3C);
		`CHK("low_threshold", 16'h0000, low_threshold)
		wr(8'h85, 8'h12);
		@(negedge clk);
		`CHK("low_threshold", 16'h123C, low_threshold)
		$display("t_regs done");
	endtask
	task automatic t_max;
		int tab[6] = '{1, 0, 17, 63, 64, 255};
		int e;
		foreach (tab[i]) begin
			wr(8'h81, tab[i][7:0]);
			@(negedge clk);
			e = (tab[i] + 1) * 1024 - 1;
			if (e > 65535) e = 65535;
			`CHK("max_count", e[15:0], max_count)
		end
		rd_chk(8'h81, 8'hFF);
		$display("t_max done");
	endtask
	task automatic t_cycle;
		u_host.start(8'h01, 8'h00, 8'h0B);
		phase_len(2, n);
		`CHK("az_len", 1'b1, n > 0 && n <= SC)
		phase_len(1, n);
		`CHK("integ_len", 2 * SC, n)
		phase_len(0, n);
		`CHK("wait_len", SC, n)
		phase_len(1, n);
		`CHK("integ_len", 2 * SC, n)
		wr(8'h8D, 8'h84);
		phase_len(1, n);
		phase_len(0, n);
		`CHK("long_wait_len", 12 * SC, n)
		wr(8'h8D, 8'h80);
		$display("t_cycle done");
	endtask
	task automatic t_nowait;
		wr(8'h80, 8'h03);
		count_hi(1, 6 * SC, n);
		`CHK("integ_cycles", 6 * SC, n)
		count_hi(0, 6 * SC, n);
		`CHK("wait_cycles", 0, n)
		count_hi(5, 6 * SC, n);
		`CHK("done_pulses", 3, n)
		$display("t_nowait done");
	endtask
	task automatic t_off;
		wr(8'h80, 8'h01);
		@(negedge clk);
		`CHK("status", 4'h8, status)
		count_hi(4, 2 * SC, n);
		`CHK("ticks_on", 2, n)
		wr(8'h80, 8'h00);
		count_hi(4, 3 * SC, n);
		`CHK("ticks_off", 0, n)
		wr(8'h80, 8'h08);
		count_hi(1, 3 * SC, n);
		`CHK("integ_unpowered", 0, n)
		$display("t_off done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		t_regs;
		t_max;
		t_cycle;
		t_nowait;
		t_off;
		end_sim;
	end
	initial begin
		#400000;
		error_cnt++;
		end_sim;
	end
endmodule
